// [rtl/prime_power_run_sequencer.sv]
// Prime power run sequencer alternating a load between two generator sets.
//
// Contract
// - Each generator runs its own duration, then alternate.
// - Offer run only in dual generator mode.
// - No prime power on service entrance models.
// - Saved start stores durations and begins sequence.
// - Saved stop in protected setup ends sequence.
// - Show countdown of running generator's remaining time.
// - Closed transition overlaps; others break before make.
// - Running generator becomes the preferred source.
// - End button cuts run, transfers to alternate.
// - Outgoing generator cools down, then start drops.
// - Start contact held closed through cool-down delay.
// - Engine start delay before start, default 3s.
// - Cool-down defaults: source 2 5s, source 1 2s.
// - Transfer delay 3s/15min defaults, up to 60min.
// - Off-position delay on programmed transition, default 1s.
// - Fail-to-acquire fault when source never becomes available.
// - Sync timeout invokes programmed-transition override.
// - In-phase window expiry raises fail-to-sync fault.
// - Per-load disconnect and reconnect delays per direction.
// - Longest disconnect delay sets time before transfer.
`timescale 1ns/1ps
`default_nettype none
module prime_power_run_sequencer
  import prime_run_pkg::*;
#(
  parameter int NUM_LOADS = 9,
  parameter int TICK_CYCLES = SEC_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic dual_gen_mode,
  input wire logic service_entrance,
  input wire logic closed_transition,
  input wire logic programmed_transition,
  input wire logic inphase_enable,
  input wire logic cfg_custom,
  input wire logic [6:0] run_days_s1,
  input wire logic [4:0] run_hours_s1,
  input wire logic [5:0] run_mins_s1,
  input wire logic [6:0] run_days_s2,
  input wire logic [4:0] run_hours_s2,
  input wire logic [5:0] run_mins_s2,
  input wire logic [2*DW-1:0] start_dly,
  input wire logic [2*DW-1:0] cool_dly,
  input wire logic [DW-1:0] xfr_p2s_dly,
  input wire logic [DW-1:0] xfr_s2p_dly,
  input wire logic [DW-1:0] off_p2s_dly,
  input wire logic [DW-1:0] off_s2p_dly,
  input wire logic [DW-1:0] preferred_acquire_timeout,
  input wire logic [DW-1:0] standby_acquire_timeout,
  input wire logic [DW-1:0] sync_timeout,
  input wire logic [DW-1:0] inphase_window,
  input wire logic [2*NUM_LOADS*DW-1:0] load_disc_dly,
  input wire logic [2*NUM_LOADS*DW-1:0] load_rec_dly,
  input wire logic setup_unlocked,
  input wire logic event_save,
  input wire logic event_start,
  input wire logic end_td_button,
  input wire logic [1:0] src_avail,
  input wire logic in_sync,
  input wire logic in_phase,
  output logic [1:0] gen_start_r,
  output logic [1:0] src_close_r,
  output logic preferred_is_s2_r,
  output logic run_active_r,
  output logic prime_offered_r,
  output logic [TW-1:0] countdown_r,
  output logic fault_acq_pref_r,
  output logic fault_acq_stby_r,
  output logic fault_sync_r,
  output logic ptrans_override_r,
  output logic [NUM_LOADS-1:0] load_shed_r
);
  initial
  begin
    if (NUM_LOADS < 1 || NUM_LOADS > 9 || TICK_CYCLES < 2)
      $error("prime_power_run_sequencer: unsupported parameter value");
  end

  // ----------------------------------------
  // Time base and timers
  // ----------------------------------------
  seq_state_t state_r, state_nxt;
  logic tick, tmr_load, tmr_done, cool_load, cool_done;
  logic [TW-1:0] tmr_val, tmr_cnt, cool_cnt;
  logic tgt_r, first_r, cool_busy_r, cool_gen_r;
  logic [TW-1:0] run_s1_r, run_s2_r;
  logic [DW-1:0] elapsed_r;

  sec_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  sec_timer u_main_tmr (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .load(tmr_load),
    .load_val(tmr_val),
    .count(tmr_cnt),
    .done(tmr_done)
  );

  sec_timer u_cool_tmr (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .load(cool_load),
    .load_val(cool_dly_sel(~tgt_r)),
    .count(cool_cnt),
    .done(cool_done)
  );

  // ----------------------------------------
  // Delay selection with defaults and limits
  // ----------------------------------------
  function automatic logic [DW-1:0] lim(input logic [DW-1:0] v,
                                        input logic [DW-1:0] lo,
                                        input logic [DW-1:0] hi);
    lim = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [TW-1:0] start_dly_sel(input logic s);
    logic [DW-1:0] d;
    d = s ? DEF_START_S2 : DEF_START_S1;
    if (cfg_custom)
      d = start_dly[s*DW +: DW];
    start_dly_sel = TW'(d);
  endfunction

  function automatic logic [TW-1:0] cool_dly_sel(input logic s);
    logic [DW-1:0] d;
    d = s ? DEF_COOL_S2 : DEF_COOL_S1;
    if (cfg_custom)
      d = lim(cool_dly[s*DW +: DW], 12'h000, MAX_DLY);
    cool_dly_sel = TW'(d);
  endfunction

  logic incoming_ok, both_ok, acq_pref;
  logic [DW-1:0] xfr_sel, off_sel, acq_sel, sync_sel, ph_sel, xfr_total;
  logic [DW-1:0] disc [NUM_LOADS];
  logic [DW-1:0] rec [NUM_LOADS];

  assign incoming_ok = src_avail[tgt_r];
  assign both_ok = &src_avail;
  assign acq_pref = (tgt_r == preferred_is_s2_r);

  always_comb
  begin
    if (cfg_custom)
    begin
      xfr_sel = lim(first_r ? xfr_s2p_dly : xfr_p2s_dly, 12'h000, MAX_DLY);
      off_sel = lim(first_r ? off_s2p_dly : off_p2s_dly, MIN_OFF, MAX_DLY);
      acq_sel = lim(acq_pref ? preferred_acquire_timeout : standby_acquire_timeout,
                    12'h000, MAX_DLY);
      sync_sel = lim(sync_timeout, MIN_SYNC, MAX_SYNC);
      ph_sel = inphase_window;
    end
    else
    begin
      xfr_sel = first_r ? DEF_XFR_S2P : DEF_XFR_P2S;
      off_sel = DEF_OFF;
      acq_sel = acq_pref ? DEF_ACQ_PREF : DEF_ACQ_STBY;
      sync_sel = DEF_SYNC;
      ph_sel = DEF_INPHASE;
    end
    xfr_total = xfr_sel;
    for (int i = 0; i < NUM_LOADS; i++)
    begin
      if (both_ok && disc[i] > xfr_total)
        xfr_total = disc[i];
    end
  end

  // ----------------------------------------
  // Per-load disconnect and reconnect
  // ----------------------------------------
  for (genvar i = 0; i < NUM_LOADS; i++)
  begin : g_load
    assign disc[i] = cfg_custom
      ? lim(load_disc_dly[(tgt_r*NUM_LOADS+i)*DW +: DW], 12'h000, MAX_DLY) : DEF_LOAD;
    assign rec[i] = cfg_custom
      ? lim(load_rec_dly[(tgt_r*NUM_LOADS+i)*DW +: DW], 12'h000, MAX_DLY) : DEF_LOAD;

    always_ff @(posedge ref_clk)
    begin
      if (sys_rst || state_r == ST_IDLE)
        load_shed_r[i] <= 1'b0;
      else if (state_r == ST_XFR && both_ok && tmr_cnt <= TW'(disc[i]))
        load_shed_r[i] <= 1'b1;
      else if (state_r == ST_RUN && elapsed_r >= rec[i])
        load_shed_r[i] <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic start_req, stop_req;
  assign start_req = event_save && event_start && setup_unlocked
                     && dual_gen_mode && !service_entrance;
  assign stop_req = event_save && !event_start && setup_unlocked;

  always_comb
  begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_val = '0;
    if (stop_req)
      state_nxt = ST_IDLE;
    else if (start_req)
    begin
      state_nxt = ST_START;
      tmr_load = 1'b1;
      tmr_val = start_dly_sel(1'b0);
    end
    else
    begin
      case (state_r)
        ST_START:
          if (tmr_done)
          begin
            state_nxt = ST_ACQUIRE;
            tmr_load = 1'b1;
            tmr_val = TW'(acq_sel);
          end
        ST_ACQUIRE:
          if (incoming_ok)
          begin
            state_nxt = ST_XFR;
            tmr_load = 1'b1;
            tmr_val = TW'(xfr_total);
          end
        ST_XFR:
          if (!incoming_ok)
          begin
            state_nxt = ST_ACQUIRE;
            tmr_load = 1'b1;
            tmr_val = TW'(acq_sel);
          end
          else if (tmr_done)
          begin
            tmr_load = 1'b1;
            if (both_ok && (closed_transition || inphase_enable))
            begin
              state_nxt = ST_SYNC;
              tmr_val = TW'(closed_transition ? sync_sel : ph_sel);
            end
            else
              state_nxt = ST_OPEN;
          end
        ST_SYNC:
          if (closed_transition && in_sync)
            state_nxt = ST_OVERLAP;
          else if ((!closed_transition && in_phase) || tmr_done)
            state_nxt = ST_OPEN;
        ST_OPEN:
        begin
          state_nxt = programmed_transition ? ST_OFF : ST_CLOSE;
          tmr_load = 1'b1;
          tmr_val = TW'(off_sel);
        end
        ST_OFF:
          if (tmr_done)
            state_nxt = ST_CLOSE;
        ST_OVERLAP:
          state_nxt = ST_CLOSE;
        ST_CLOSE:
        begin
          state_nxt = ST_RUN;
          tmr_load = 1'b1;
          tmr_val = tgt_r ? run_s2_r : run_s1_r;
        end
        ST_RUN:
          if (tmr_done || end_td_button)
          begin
            state_nxt = ST_START;
            tmr_load = 1'b1;
            tmr_val = start_dly_sel(~tgt_r);
          end
        default:
          state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || stop_req)
      run_active_r <= 1'b0;
    else if (start_req)
      run_active_r <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      prime_offered_r <= 1'b0;
    else
      prime_offered_r <= dual_gen_mode && !service_entrance;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      run_s1_r <= '0;
      run_s2_r <= '0;
    end
    else if (start_req)
    begin
      run_s1_r <= TW'(run_days_s1 * DAY_S) + TW'(run_hours_s1 * HOUR_S)
                  + TW'(run_mins_s1 * MINUTE_S);
      run_s2_r <= TW'(run_days_s2 * DAY_S) + TW'(run_hours_s2 * HOUR_S)
                  + TW'(run_mins_s2 * MINUTE_S);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || start_req)
    begin
      tgt_r <= 1'b0;
      first_r <= 1'b1;
    end
    else if (state_r == ST_RUN && state_nxt == ST_START)
      tgt_r <= ~tgt_r;
    else if (state_r == ST_CLOSE)
      first_r <= 1'b0;
  end

  // Swap of the preferred designation and switch contacts.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      preferred_is_s2_r <= 1'b0;
      src_close_r <= 2'b00;
    end
    else if (state_r == ST_OPEN)
      src_close_r[~tgt_r] <= 1'b0;
    else if (state_r == ST_OVERLAP)
      src_close_r[tgt_r] <= 1'b1;
    else if (state_r == ST_CLOSE)
    begin
      src_close_r[tgt_r] <= 1'b1;
      src_close_r[~tgt_r] <= 1'b0;
      preferred_is_s2_r <= tgt_r;
    end
  end

  // ----------------------------------------
  // Engine start and cool-down
  // ----------------------------------------
  assign cool_load = (state_r == ST_CLOSE) && gen_start_r[~tgt_r];

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cool_busy_r <= 1'b0;
      cool_gen_r <= 1'b0;
    end
    else if (cool_load)
    begin
      cool_busy_r <= 1'b1;
      cool_gen_r <= ~tgt_r;
    end
    else if (cool_done)
      cool_busy_r <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      gen_start_r <= 2'b00;
    else
    begin
      if (cool_busy_r && cool_done && !cool_load)
        gen_start_r[cool_gen_r] <= 1'b0;
      if (state_r == ST_START && tmr_done && !stop_req && !start_req)
        gen_start_r[tgt_r] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Countdown, elapsed time and faults
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || state_r != ST_RUN)
      countdown_r <= '0;
    else
      countdown_r <= tmr_cnt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || state_r != ST_RUN)
      elapsed_r <= '0;
    else if (tick && elapsed_r != MAX_DLY)
      elapsed_r <= elapsed_r + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || start_req)
    begin
      fault_acq_pref_r <= 1'b0;
      fault_acq_stby_r <= 1'b0;
      fault_sync_r <= 1'b0;
      ptrans_override_r <= 1'b0;
    end
    else
    begin
      if (state_r == ST_ACQUIRE && tmr_done && !incoming_ok)
      begin
        if (acq_pref)
          fault_acq_pref_r <= 1'b1;
        else
          fault_acq_stby_r <= 1'b1;
      end
      if (state_r == ST_SYNC && tmr_done && closed_transition && !in_sync)
        ptrans_override_r <= 1'b1;
      if (state_r == ST_SYNC && tmr_done && !closed_transition && !in_phase)
        fault_sync_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_run_over;
    state_r == ST_RUN && (tmr_done || end_td_button) && !stop_req && !start_req;
  endsequence

  sequence s_next_start;
    state_r == ST_START && tgt_r != $past(tgt_r);
  endsequence

  a_run_alternates: assert property (s_run_over |=> s_next_start)
    else $error("run end did not start the alternate generator");
  a_offer_mode: assert property ($rose(run_active_r) |-> $past(dual_gen_mode))
    else $error("run began outside dual generator mode");
  a_offer_entrance: assert property ($rose(run_active_r) |-> !$past(service_entrance))
    else $error("run began on a service entrance model");
  a_start_begins: assert property (start_req |=> run_active_r && state_r == ST_START)
    else $error("saved start did not begin the sequence");
  a_stop_ends: assert property (stop_req |=> !run_active_r && state_r == ST_IDLE)
    else $error("saved stop did not end the sequence");
  a_countdown_shown: assert property (state_r == ST_RUN ##1 state_r == ST_RUN
    |-> countdown_r == $past(tmr_cnt))
    else $error("countdown does not follow the run timer");
  a_overlap_make: assert property (state_r == ST_OVERLAP |=> &src_close_r)
    else $error("closed transition lost the overlap");
  a_break_make: assert property (state_r == ST_OPEN |=> !src_close_r[~tgt_r])
    else $error("outgoing source not opened before closing");
  a_pref_swap: assert property (state_r == ST_CLOSE |=> preferred_is_s2_r == tgt_r)
    else $error("preferred source not swapped to running generator");
  a_cool_hold: assert property (cool_busy_r && !cool_done |-> gen_start_r[cool_gen_r])
    else $error("start dropped during cool-down");
  a_fail_acquire: assert property (state_r == ST_ACQUIRE && tmr_done && !incoming_ok
    |=> fault_acq_pref_r || fault_acq_stby_r)
    else $error("missing fail-to-acquire fault");
  a_sync_override: assert property (state_r == ST_SYNC && tmr_done && closed_transition
    && !in_sync && !stop_req && !start_req
    |=> ptrans_override_r && state_r == ST_OPEN)
    else $error("sync timeout did not override");
  a_cancel_delay: assert property (state_r == ST_XFR && !incoming_ok && !stop_req
    && !start_req |=> state_r == ST_ACQUIRE)
    else $error("transfer delay not cancelled");
endmodule
`default_nettype wire

// [rtl/prime_run_pkg.sv]
// Shared constants and types for the prime power run sequencer.
package prime_run_pkg;
  // ----------------------------------------
  // Time base
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEC_NS = 1_000_000_000;
  localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
  localparam int TW = 24;
  localparam int DW = 12;
  localparam logic [TW-1:0] MINUTE_S = 24'h00003c;
  localparam logic [TW-1:0] HOUR_S = 24'h000e10;
  localparam logic [TW-1:0] DAY_S = 24'h015180;
  // ----------------------------------------
  // Delay defaults and limits, in seconds
  // ----------------------------------------
  localparam logic [DW-1:0] DEF_START_S1 = 12'h003;
  localparam logic [DW-1:0] DEF_START_S2 = 12'h003;
  localparam logic [DW-1:0] DEF_COOL_S1 = 12'h002;
  localparam logic [DW-1:0] DEF_COOL_S2 = 12'h005;
  localparam logic [DW-1:0] DEF_XFR_P2S = 12'h003;
  localparam logic [DW-1:0] DEF_XFR_S2P = 12'h384;
  localparam logic [DW-1:0] DEF_OFF = 12'h001;
  localparam logic [DW-1:0] DEF_ACQ_PREF = 12'h03c;
  localparam logic [DW-1:0] DEF_ACQ_STBY = 12'h03c;
  localparam logic [DW-1:0] DEF_SYNC = 12'h03c;
  localparam logic [DW-1:0] DEF_INPHASE = 12'h01e;
  localparam logic [DW-1:0] DEF_LOAD = 12'h000;
  localparam logic [DW-1:0] MAX_DLY = 12'he10;
  localparam logic [DW-1:0] MIN_OFF = 12'h001;
  localparam logic [DW-1:0] MIN_SYNC = 12'h00a;
  localparam logic [DW-1:0] MAX_SYNC = 12'h384;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_START = 10'h002,
    ST_ACQUIRE = 10'h004,
    ST_XFR = 10'h008,
    ST_SYNC = 10'h010,
    ST_OPEN = 10'h020,
    ST_OFF = 10'h040,
    ST_OVERLAP = 10'h080,
    ST_CLOSE = 10'h100,
    ST_RUN = 10'h200
  } seq_state_t;
endpackage

// [rtl/sec_tick.sv]
// One-second tick generator dividing the reference clock.
`timescale 1ns/1ps
`default_nettype none
module sec_tick
  import prime_run_pkg::*;
#(
  parameter int CYCLES = SEC_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  output logic tick
);
  localparam int CW = (CYCLES > 2) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] div_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || div_r == LAST)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  assign tick = (div_r == LAST);
endmodule
`default_nettype wire

// [rtl/sec_timer.sv]
// Loadable seconds down-counter.
`timescale 1ns/1ps
`default_nettype none
module sec_timer
  import prime_run_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic load,
  input wire logic [TW-1:0] load_val,
  output logic [TW-1:0] count,
  output logic done
);
  logic skip_r;

  // The first tick after a load ends a partial second and is not counted.
  // This keeps a delay of N seconds from running short of N whole seconds.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      skip_r <= 1'b0;
    else if (load)
      skip_r <= 1'b1;
    else if (tick)
      skip_r <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      count <= '0;
    else if (load)
      count <= load_val;
    else if (tick && !skip_r && count != '0)
      count <= count - 1'b1;
  end

  assign done = (count == '0);
endmodule
`default_nettype wire

// [dv/gen_pair_model.sv]
// Behavioural model of the two generator sets seen by the sequencer.
`timescale 1ns/1ps
`default_nettype none
module gen_pair_model #(
  parameter int UP_CYCLES = 6
)
(
  input wire logic ref_clk,
  input wire logic [1:0] gen_start,
  input wire logic [1:0] hold_off,
  input wire logic sync_ok,
  output logic [1:0] src_avail,
  output logic in_sync,
  output logic in_phase
);
  int run_cnt [2] = '{0, 0};
  // A set reaches acceptable voltage only after running for a while.
  // A held-off set never does, which lets a scenario starve the sequencer.
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      run_cnt[i] <= (gen_start[i] && !hold_off[i]) ? run_cnt[i] + 1 : 0;
    end
  end
  assign src_avail[0] = run_cnt[0] >= UP_CYCLES;
  assign src_avail[1] = run_cnt[1] >= UP_CYCLES;
  assign in_sync = (&src_avail) & sync_ok;
  assign in_phase = (&src_avail) & sync_ok;
endmodule
`default_nettype wire

// [dv/prime_power_run_sequencer_test.sv]
// Self-checking testbench of the prime power run sequencer.
`timescale 1ns/1ps
`default_nettype none
module prime_power_run_sequencer_test;
  import prime_run_pkg::*;
  localparam int TK = 4;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic dual_gen_mode, service_entrance, closed_transition, programmed_transition;
  logic inphase_enable, cfg_custom, setup_unlocked, event_save, event_start;
  logic end_td_button, sync_ok;
  logic [1:0] hold_off;
  logic [6:0] run_days_s1, run_days_s2;
  logic [4:0] run_hours_s1, run_hours_s2;
  logic [5:0] run_mins_s1, run_mins_s2;
  logic [2*DW-1:0] start_dly, cool_dly, load_disc_dly, load_rec_dly;
  logic [DW-1:0] xfr_p2s_dly, xfr_s2p_dly, off_p2s_dly, off_s2p_dly;
  logic [DW-1:0] preferred_acquire_timeout, standby_acquire_timeout;
  logic [DW-1:0] sync_timeout, inphase_window;
  logic [1:0] src_avail, gen_start_r, src_close_r;
  logic in_sync, in_phase, preferred_is_s2_r, run_active_r, prime_offered_r;
  logic [TW-1:0] countdown_r;
  logic fault_acq_pref_r, fault_acq_stby_r, fault_sync_r, ptrans_override_r;
  logic [0:0] load_shed_r;
  logic overlap_seen = 1'b0;
  logic shed_seen = 1'b0;
  int bad_count = 0;
  int checked = 0;
  int n;
  wire logic [5:0] watch = {fault_acq_pref_r, src_avail[1], src_close_r, gen_start_r};

  always #5 ref_clk = ~ref_clk;

  prime_power_run_sequencer #(.NUM_LOADS(1), .TICK_CYCLES(TK)) i_dut (
    .ref_clk, .sys_rst, .dual_gen_mode, .service_entrance, .closed_transition,
    .programmed_transition, .inphase_enable, .cfg_custom, .run_days_s1, .run_hours_s1,
    .run_mins_s1, .run_days_s2, .run_hours_s2, .run_mins_s2, .start_dly, .cool_dly,
    .xfr_p2s_dly, .xfr_s2p_dly, .off_p2s_dly, .off_s2p_dly, .preferred_acquire_timeout,
    .standby_acquire_timeout, .sync_timeout, .inphase_window, .load_disc_dly,
    .load_rec_dly, .setup_unlocked, .event_save, .event_start, .end_td_button,
    .src_avail, .in_sync, .in_phase, .gen_start_r, .src_close_r, .preferred_is_s2_r,
    .run_active_r, .prime_offered_r, .countdown_r, .fault_acq_pref_r, .fault_acq_stby_r,
    .fault_sync_r, .ptrans_override_r, .load_shed_r
  );

  gen_pair_model #(.UP_CYCLES(6)) i_gens (
    .ref_clk, .gen_start(gen_start_r), .hold_off, .sync_ok, .src_avail, .in_sync,
    .in_phase
  );

  // Overlap and shedding are short-lived, so they are latched here.
  always @(posedge ref_clk)
  begin
    if (src_close_r === 2'b11)
      overlap_seen = 1'b1;
    if (load_shed_r[0] === 1'b1)
      shed_seen = 1'b1;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [TW-1:0] seen,
                       input logic [TW-1:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_for(input int sel, input logic val, output int cnt);
    cnt = 0;
    do
    begin
      step();
      cnt++;
    end while (watch[sel] !== val && cnt < 2000);
    if (cnt >= 2000)
      bad_count++;
  endtask

  task automatic save(input logic start);
    event_start = start;
    event_save = 1'b1;
    step();
    event_save = 1'b0;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    {service_entrance, closed_transition, programmed_transition} = 3'h0;
    {inphase_enable, event_save, event_start, end_td_button, sync_ok} = 5'h00;
    {dual_gen_mode, cfg_custom, setup_unlocked} = 3'h7;
    hold_off = 2'h0;
    {run_days_s1, run_hours_s1, run_mins_s1} = {7'h00, 5'h00, 6'h01};
    {run_days_s2, run_hours_s2, run_mins_s2} = {7'h00, 5'h00, 6'h02};
    start_dly = {12'h001, 12'h002};
    cool_dly = {12'h003, 12'h002};
    load_disc_dly = {12'h005, 12'h000};
    load_rec_dly = 24'h000000;
    {xfr_p2s_dly, xfr_s2p_dly, off_p2s_dly, off_s2p_dly} = {4{12'h001}};
    {preferred_acquire_timeout, standby_acquire_timeout} = {2{12'h03c}};
    sync_timeout = 12'h00a;
    inphase_window = 12'h01e;
    repeat (5) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    dual_gen_mode = 1'b0;
    step();
    check("offered", prime_offered_r, 0);
    save(1'b1);
    check("active", run_active_r, 0);
    dual_gen_mode = 1'b1;
    service_entrance = 1'b1;
    step();
    check("offered", prime_offered_r, 0);
    save(1'b1);
    check("active", run_active_r, 0);
    service_entrance = 1'b0;
    step();
    check("offered", prime_offered_r, 1);
    $display("test refusal done");
    save(1'b1);
    check("active", run_active_r, 1);
    wait_for(0, 1'b1, n);
    check("start delay", n >= 2*TK-1 && n <= 3*TK+1, 1);
    wait_for(2, 1'b1, n);
    check("preferred", preferred_is_s2_r, 0);
    step();
    check("countdown", countdown_r >= 58 && countdown_r <= 60, 1);
    wait_for(1, 1'b1, n);
    check("s1 run", n >= 60*TK && n <= 63*TK, 1);
    wait_for(4, 1'b1, n);
    wait_for(3, 1'b1, n);
    check("pre delay", n >= 5*TK-1 && n <= 7*TK+2, 1);
    check("shed", shed_seen, 1);
    check("overlap", overlap_seen, 0);
    check("preferred", preferred_is_s2_r, 1);
    step();
    check("countdown", countdown_r >= 118 && countdown_r <= 120, 1);
    wait_for(0, 1'b0, n);
    check("cool down", n >= 2*TK-1 && n <= 3*TK+2, 1);
    $display("test alternation done");
    closed_transition = 1'b1;
    sync_ok = 1'b1;
    end_td_button = 1'b1;
    step();
    end_td_button = 1'b0;
    wait_for(0, 1'b1, n);
    check("end start", n <= 3*TK+2, 1);
    wait_for(2, 1'b1, n);
    step();
    check("overlap", overlap_seen, 1);
    check("preferred", preferred_is_s2_r, 0);
    step();
    check("countdown", countdown_r >= 58 && countdown_r <= 60, 1);
    check("override", ptrans_override_r, 0);
    check("sync fault", fault_sync_r, 0);
    save(1'b0);
    check("active", run_active_r, 0);
    $display("test end button and stop done");
    sys_rst = 1'b1;
    repeat (2) step();
    sys_rst = 1'b0;
    hold_off = 2'h1;
    preferred_acquire_timeout = 12'h003;
    save(1'b1);
    wait_for(5, 1'b1, n);
    check("acquire fault", n >= 5*TK-1 && n <= 7*TK+2, 1);
    check("standby fault", fault_acq_stby_r, 0);
    $display("test acquire fault done");
    print_verdict();
  end

  initial
  begin
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
